// ===== verilog/ocmc_consts.svh
`ifndef OCMC_CONSTS_SVH
`define OCMC_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define OCMC_IDX_LEVEL_LOW   6'h14
`define OCMC_IDX_LEVEL_UP    6'h15
`define OCMC_IDX_MUTE_EN     6'h16
`define OCMC_IDX_STATUS      6'h17
`define OCMC_IDX_P_STATE     6'h18
`define OCMC_IDX_N_STATE     6'h19
`define OCMC_IDX_HISTORY     6'h1A

// reset values
`define OCMC_MUTE_EN_RESET   8'hFF
`define OCMC_LEVEL_RESET     8'h55
`define OCMC_HISTORY_RESET   8'h00
`define OCMC_SRC_VALID_RESET 1'b0

// mute enable bit of each channel
`define OCMC_CH0_BIT         0
`define OCMC_CH1_BIT         1
`define OCMC_CH2_BIT         2
`define OCMC_CH3_BIT         3
`define OCMC_CH4_BIT         4
`define OCMC_CH5_BIT         5
`define OCMC_CH6_BIT         6
`define OCMC_CH7_BIT         7

// level fields: channel 4 (or 0) at [1:0] up to channel 7 (or 3) at [7:6]
`define OCMC_LVL_WIDTH       2
`define OCMC_NUM_CH          8
`define OCMC_CH_PER_REG      4

// status word layout
`define OCMC_STAT_SRC_BIT    8

`endif

// ===== verilog/ocmc_pkg.sv
package ocmc_pkg;

    // condition presented on one driver pin
    typedef enum logic [2:0] {
        OCMC_PIN_NORMAL = 3'h0,
        OCMC_PIN_LOW    = 3'h1,
        OCMC_PIN_HIGH   = 3'h2,
        OCMC_PIN_VCM    = 3'h3,
        OCMC_PIN_RAIL   = 3'h4
    } ocmc_pin_t;

    typedef enum logic [1:0] {
        OCMC_LVL_BYPASS = 2'h0,
        OCMC_LVL_PWRDN  = 2'h1,
        OCMC_LVL_FORCE  = 2'h2,
        OCMC_LVL_RAIL   = 2'h3
    } ocmc_level_t;

    typedef enum logic {
        OCMC_BUS_IDLE = 1'b0,
        OCMC_BUS_ACK  = 1'b1
    } ocmc_bus_st_t;

endpackage

// ===== verilog/ocmc_chan_gate.sv
`timescale 1ns/1ps
module ocmc_chan_gate (
    input  wire logic          core_clk,
    input  wire logic          reset_n,
    input  wire logic          auto_disable,
    input  wire logic          src_valid,
    input  wire logic [1:0]    level,
    input  wire logic          diff_mode,
    input  wire logic          div_edge,
    output ocmc_pkg::ocmc_pin_t p_state,
    output ocmc_pkg::ocmc_pin_t n_state,
    output logic               muted
);

    logic                muted_reg;
    logic                muted_next;
    ocmc_pkg::ocmc_pin_t p_reg;
    ocmc_pkg::ocmc_pin_t p_next;
    ocmc_pkg::ocmc_pin_t n_reg;
    ocmc_pkg::ocmc_pin_t n_next;
    logic [5:0]          pin_pair;

    // returns {p, n} pin conditions for a mute state, level and drive mode
    function automatic logic [5:0] pin_decode(
        input logic       is_muted,
        input logic [1:0] lvl,
        input logic       diff
    );
        ocmc_pkg::ocmc_pin_t p;
        ocmc_pkg::ocmc_pin_t n;
        p = ocmc_pkg::OCMC_PIN_NORMAL;
        n = ocmc_pkg::OCMC_PIN_NORMAL;
        if (is_muted && diff) begin
            case (ocmc_pkg::ocmc_level_t'(lvl))
                ocmc_pkg::OCMC_LVL_PWRDN: begin
                    p = ocmc_pkg::OCMC_PIN_VCM;
                    n = ocmc_pkg::OCMC_PIN_VCM;
                end
                ocmc_pkg::OCMC_LVL_FORCE: begin
                    p = ocmc_pkg::OCMC_PIN_HIGH;
                    n = ocmc_pkg::OCMC_PIN_LOW;
                end
                ocmc_pkg::OCMC_LVL_RAIL: begin
                    p = ocmc_pkg::OCMC_PIN_RAIL;
                    n = ocmc_pkg::OCMC_PIN_LOW;
                end
                default: begin
                    p = ocmc_pkg::OCMC_PIN_NORMAL;
                    n = ocmc_pkg::OCMC_PIN_NORMAL;
                end
            endcase
        end else if (is_muted) begin
            case (ocmc_pkg::ocmc_level_t'(lvl))
                ocmc_pkg::OCMC_LVL_PWRDN: begin
                    p = ocmc_pkg::OCMC_PIN_NORMAL;
                    n = ocmc_pkg::OCMC_PIN_LOW;
                end
                ocmc_pkg::OCMC_LVL_FORCE: begin
                    p = ocmc_pkg::OCMC_PIN_LOW;
                    n = ocmc_pkg::OCMC_PIN_NORMAL;
                end
                ocmc_pkg::OCMC_LVL_RAIL: begin
                    p = ocmc_pkg::OCMC_PIN_LOW;
                    n = ocmc_pkg::OCMC_PIN_LOW;
                end
                default: begin
                    p = ocmc_pkg::OCMC_PIN_NORMAL;
                    n = ocmc_pkg::OCMC_PIN_NORMAL;
                end
            endcase
        end
        return {p, n};
    endfunction

    // state moves only on the channel's own divided edge
    always_comb begin
        muted_next = muted_reg;
        p_next     = p_reg;
        n_next     = n_reg;
        pin_pair   = pin_decode(auto_disable & ~src_valid, level, diff_mode);
        if (div_edge) begin
            muted_next = auto_disable & ~src_valid;
            p_next     = ocmc_pkg::ocmc_pin_t'(pin_pair[5:3]);
            n_next     = ocmc_pkg::ocmc_pin_t'(pin_pair[2:0]);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            muted_reg <= 1'b0;
            p_reg     <= ocmc_pkg::OCMC_PIN_NORMAL;
            n_reg     <= ocmc_pkg::OCMC_PIN_NORMAL;
        end else begin
            muted_reg <= muted_next;
            p_reg     <= p_next;
            n_reg     <= n_next;
        end
    end

    assign muted   = muted_reg;
    assign p_state = p_reg;
    assign n_state = n_reg;

endmodule

// ===== verilog/ocmc_top.sv
// Summary of operation
// - differential muted channel 4 level: bypass, common-mode, high, rail/ground.
// - single-ended muted channel 4 level: bypass, N low, P low, both low.
// - level shapes the muted output only; enable bit and source-valid together decide muting.
// - channel 7 enable set mutes channel 7 while source invalid.
// - channel 6 enable set mutes channel 6 while source invalid.
// - channel 5 enable set mutes channel 5 while source invalid.
// - channel 4 enable set mutes channel 4 while source invalid.
// - channel 3 enable set mutes channel 3 while source invalid.
// - channel 2 enable set mutes channel 2 while source invalid.
// - channel 1 enable set mutes channel 1 while source invalid.
// - channel 0 enable set mutes channel 0 while source invalid.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "ocmc_consts.svh"
module ocmc_top (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        src_valid_in,
    input  wire logic [7:0]  chan_diff_mode,
    input  wire logic [7:0]  chan_div_edge,
    output logic      [7:0]  chan_muted,
    output logic      [23:0] chan_p_state,
    output logic      [23:0] chan_n_state
);

    // bus handshake state
    ocmc_pkg::ocmc_bus_st_t bus_st_reg;
    ocmc_pkg::ocmc_bus_st_t bus_st_next;
    logic                   wait_reg;
    logic                   wait_next;
    logic [31:0]            rdata_reg;
    logic [31:0]            rdata_next;

    // software registers
    logic [7:0]             mute_en_reg;
    logic [7:0]             mute_en_next;
    logic [7:0]             level_up_reg;
    logic [7:0]             level_up_next;
    logic [7:0]             level_low_reg;
    logic [7:0]             level_low_next;
    logic [7:0]             history_reg;
    logic [7:0]             history_next;

    // source-valid synchroniser
    logic                   src_meta_reg;
    logic                   src_meta_next;
    logic                   src_sync_reg;
    logic                   src_sync_next;

    // internal wires
    logic                   bus_req;
    logic                   wr_commit;
    logic [5:0]             wr_index;
    logic [31:0]            read_word;
    logic [7:0]             auto_dis;
    logic [15:0]            level_all;
    logic [7:0]             muted_w;
    ocmc_pkg::ocmc_pin_t    p_w [`OCMC_NUM_CH];
    ocmc_pkg::ocmc_pin_t    n_w [`OCMC_NUM_CH];
    logic [23:0]            p_flat;
    logic [23:0]            n_flat;

    // word index of a byte address; low two bits are ignored
    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        return addr[7:2];
    endfunction

    // ------------------------------------------------------------------
    // source-valid crosses in from the reference detector
    always_comb begin
        src_meta_next = src_valid_in;
        src_sync_next = src_meta_reg;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_meta_reg <= `OCMC_SRC_VALID_RESET;
            src_sync_reg <= `OCMC_SRC_VALID_RESET;
        end else begin
            src_meta_reg <= src_meta_next;
            src_sync_reg <= src_sync_next;
        end
    end

    // ------------------------------------------------------------------
    // Avalon slave: one wait cycle, then a single ack cycle
    assign bus_req   = avs_read | avs_write;
    assign wr_index  = reg_index(avs_address);
    assign wr_commit = (bus_st_reg == ocmc_pkg::OCMC_BUS_ACK) &
                       avs_write & avs_byteenable[0];

    always_comb begin
        read_word = 32'h0000_0000;
        case (reg_index(avs_address))
            `OCMC_IDX_MUTE_EN: begin
                read_word[7:0] = mute_en_reg;
            end
            `OCMC_IDX_LEVEL_UP: begin
                read_word[7:0] = level_up_reg;
            end
            `OCMC_IDX_LEVEL_LOW: begin
                read_word[7:0] = level_low_reg;
            end
            `OCMC_IDX_STATUS: begin
                read_word[7:0] = muted_w;
                read_word[`OCMC_STAT_SRC_BIT] = src_sync_reg;
            end
            `OCMC_IDX_P_STATE: begin
                read_word[23:0] = p_flat;
            end
            `OCMC_IDX_N_STATE: begin
                read_word[23:0] = n_flat;
            end
            `OCMC_IDX_HISTORY: begin
                read_word[7:0] = history_reg;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        bus_st_next = bus_st_reg;
        wait_next   = 1'b1;
        rdata_next  = rdata_reg;
        case (bus_st_reg)
            ocmc_pkg::OCMC_BUS_IDLE: begin
                if (bus_req) begin
                    bus_st_next = ocmc_pkg::OCMC_BUS_ACK;
                    wait_next   = 1'b0;
                    if (avs_read) begin
                        rdata_next = read_word;
                    end
                end
            end
            ocmc_pkg::OCMC_BUS_ACK: begin
                bus_st_next = ocmc_pkg::OCMC_BUS_IDLE;
                wait_next   = 1'b1;
            end
            default: begin
                bus_st_next = ocmc_pkg::OCMC_BUS_IDLE;
                wait_next   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_st_reg <= ocmc_pkg::OCMC_BUS_IDLE;
            wait_reg   <= 1'b1;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            bus_st_reg <= bus_st_next;
            wait_reg   <= wait_next;
            rdata_reg  <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // register writes; muting in history wins over a clear
    always_comb begin
        mute_en_next   = mute_en_reg;
        level_up_next  = level_up_reg;
        level_low_next = level_low_reg;
        history_next   = history_reg;
        if (wr_commit) begin
            case (wr_index)
                `OCMC_IDX_MUTE_EN: begin
                    mute_en_next = avs_writedata[7:0];
                end
                `OCMC_IDX_LEVEL_UP: begin
                    level_up_next = avs_writedata[7:0];
                end
                `OCMC_IDX_LEVEL_LOW: begin
                    level_low_next = avs_writedata[7:0];
                end
                `OCMC_IDX_HISTORY: begin
                    history_next = history_reg & ~avs_writedata[7:0];
                end
                default: begin
                    mute_en_next = mute_en_reg;
                end
            endcase
        end
        history_next = history_next | muted_w;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mute_en_reg   <= `OCMC_MUTE_EN_RESET;
            level_up_reg  <= `OCMC_LEVEL_RESET;
            level_low_reg <= `OCMC_LEVEL_RESET;
            history_reg   <= `OCMC_HISTORY_RESET;
        end else begin
            mute_en_reg   <= mute_en_next;
            level_up_reg  <= level_up_next;
            level_low_reg <= level_low_next;
            history_reg   <= history_next;
        end
    end

    // ------------------------------------------------------------------
    // per-channel auto-disable enables
    assign auto_dis[7] = mute_en_reg[`OCMC_CH7_BIT];
    assign auto_dis[6] = mute_en_reg[`OCMC_CH6_BIT];
    assign auto_dis[5] = mute_en_reg[`OCMC_CH5_BIT];
    assign auto_dis[4] = mute_en_reg[`OCMC_CH4_BIT];
    assign auto_dis[3] = mute_en_reg[`OCMC_CH3_BIT];
    assign auto_dis[2] = mute_en_reg[`OCMC_CH2_BIT];
    assign auto_dis[1] = mute_en_reg[`OCMC_CH1_BIT];
    assign auto_dis[0] = mute_en_reg[`OCMC_CH0_BIT];

    // channels 0..3 from the low level word, 4..7 from the upper one
    assign level_all = {level_up_reg, level_low_reg};

    genvar ch;
    generate
        for (ch = 0; ch < `OCMC_NUM_CH; ch = ch + 1) begin : g_chan
            ocmc_chan_gate u_gate (
                .core_clk     (core_clk),
                .reset_n      (reset_n),
                .auto_disable (auto_dis[ch]),
                .src_valid    (src_sync_reg),
                .level        (level_all[ch*2 +: 2]),
                .diff_mode    (chan_diff_mode[ch]),
                .div_edge     (chan_div_edge[ch]),
                .p_state      (p_w[ch]),
                .n_state      (n_w[ch]),
                .muted        (muted_w[ch])
            );
            assign p_flat[ch*3 +: 3] = p_w[ch];
            assign n_flat[ch*3 +: 3] = n_w[ch];
        end
    endgenerate

    // ------------------------------------------------------------------
    // outputs, each straight from a flip-flop
    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign chan_muted      = muted_w;
    assign chan_p_state    = p_flat;
    assign chan_n_state    = n_flat;

endmodule

// ===== tb/ocmc_top_checker.sv
`timescale 1ns/1ps
module ocmc_top_checker (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        src_valid_in,
    input wire logic [7:0]  chan_diff_mode,
    input wire logic [7:0]  chan_div_edge,
    input wire logic [7:0]  chan_muted,
    input wire logic [23:0] chan_p_state,
    input wire logic [23:0] chan_n_state
);
    logic [23:0] edge3;
    logic        bad_idle;

    // each channel's edge widened to its three-bit pin code
    always_comb begin
        bad_idle = 1'b0;
        for (int i = 0; i < 8; i++) begin
            edge3[i*3 +: 3] = {3{chan_div_edge[i]}};
            if (!chan_muted[i] && (chan_p_state[i*3 +: 3] != 3'h0 ||
                chan_n_state[i*3 +: 3] != 3'h0)) begin
                bad_idle = 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence one_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence src_good;
        src_valid_in [*3] ##1 (src_valid_in && chan_div_edge != 8'h00);
    endsequence

    ack_one_cycle_a: assert property (req_taken |=> one_ack)
        else $error("bus ack not one cycle");
    idle_wait_a: assert property (
        !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("ack without request");
    mute_hold_a: assert property (
        1'b1 |=> ((chan_muted ^ $past(chan_muted)) &
                  ~$past(chan_div_edge)) == 8'h00)
        else $error("mute changed off the divided edge");
    pins_hold_a: assert property (
        1'b1 |=> (((chan_p_state ^ $past(chan_p_state)) |
                   (chan_n_state ^ $past(chan_n_state))) &
                  ~$past(edge3)) == 24'h000000)
        else $error("pin code changed off the divided edge");
    unmuted_normal_a: assert property (!bad_idle)
        else $error("running channel with forced pins");
    rail_pair_a: assert property (
        chan_p_state[14:12] == ocmc_pkg::OCMC_PIN_RAIL |->
        chan_n_state[14:12] == ocmc_pkg::OCMC_PIN_LOW)
        else $error("rail level without grounded negative pin");
    vcm_pair_a: assert property (
        chan_p_state[14:12] == ocmc_pkg::OCMC_PIN_VCM |->
        chan_n_state[14:12] == ocmc_pkg::OCMC_PIN_VCM)
        else $error("common-mode level on one pin only");
    valid_unmute_a: assert property (
        src_good |=> (chan_muted & $past(chan_div_edge)) == 8'h00)
        else $error("channel muted with a valid source");
endmodule

// ===== tb/ocmc_top_bench.sv
`timescale 1ns/1ps
module ocmc_top_bench;
    logic        core_clk;
    logic        reset_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        src_valid_in;
    logic [7:0]  chan_diff_mode;
    logic [7:0]  chan_div_edge;
    logic [7:0]  chan_muted;
    logic [23:0] chan_p_state;
    logic [23:0] chan_n_state;
    int          n_fail;
    int          n_checks;
    localparam logic [2:0] nr = ocmc_pkg::OCMC_PIN_NORMAL;
    localparam logic [2:0] lo = ocmc_pkg::OCMC_PIN_LOW;
    localparam logic [2:0] hi = ocmc_pkg::OCMC_PIN_HIGH;
    localparam logic [2:0] vc = ocmc_pkg::OCMC_PIN_VCM;
    localparam logic [2:0] ra = ocmc_pkg::OCMC_PIN_RAIL;
    // single-ended levels 0..3, then differential levels 0..3
    logic [2:0]  exp_p [8] = '{nr, nr, lo, lo, nr, vc, hi, ra};
    logic [2:0]  exp_n [8] = '{nr, lo, nr, lo, nr, vc, lo, lo};

    ocmc_top i_ocmc_top (
        .core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .src_valid_in, .chan_diff_mode, .chan_div_edge, .chan_muted,
        .chan_p_state, .chan_n_state
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic test_done();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // hold the request until waitrequest is sampled low
    task automatic wait_ack(output logic [31:0] rd);
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] v,
                          input logic [3:0] be);
        logic [31:0] rd;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, v};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack(rd);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] rd;
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack(rd);
        chk(what, exp, rd);
    endtask

    task automatic pulse(input logic [7:0] m);
        @(posedge core_clk);
        chan_div_edge <= m;
        @(posedge core_clk);
        chan_div_edge <= 8'h00;
        @(posedge core_clk);
    endtask

    // wait past the two-flop synchroniser
    task automatic set_src(input logic v);
        @(posedge core_clk);
        src_valid_in <= v;
        repeat (4) @(posedge core_clk);
    endtask

    initial begin
        n_fail = 0;
        n_checks = 0;
        reset_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        src_valid_in = 1'b0;
        chan_diff_mode = 8'h00;
        chan_div_edge = 8'h00;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk("enables", 8'h58, 32'h000000FF);
        rd_chk("level", 8'h54, 32'h00000055);
        rd_chk("level low", 8'h50, 32'h00000055);
        bus_wr(8'h7C, 8'hFF, 4'hF);
        rd_chk("unmapped", 8'h7C, 32'h00000000);
        bus_wr(8'h58, 8'h00, 4'hE);
        rd_chk("be0 low", 8'h58, 32'h000000FF);
        pulse(8'hFF);
        chk("muted", 32'h000000FF, {24'h0, chan_muted});
        rd_chk("status", 8'h5C, 32'h000000FF);
        for (int n = 0; n < 8; n++) begin
            bus_wr(8'h58, 8'h01 << n, 4'h1);
            pulse(8'hFF);
            chk("one", 32'h1 << n, {24'h0, chan_muted});
        end
        // enables only act on each channel's own divided edge
        bus_wr(8'h58, 8'hFF, 4'h1);
        pulse(8'h01);
        chk("edge0", 32'h00000081, {24'h0, chan_muted});
        set_src(1'b1);
        pulse(8'h80);
        chk("edge7", 32'h00000001, {24'h0, chan_muted});
        rd_chk("status", 8'h5C, 32'h00000101);
        pulse(8'hFF);
        chk("valid", 32'h00000000, {24'h0, chan_muted});
        set_src(1'b0);
        for (int i = 0; i < 8; i++) begin
            chan_diff_mode <= {8{i[2]}};
            bus_wr(8'h54, 8'h54 | i[7:0] & 8'h03, 4'h1);
            pulse(8'h10);
            chk("p", exp_p[i], chan_p_state[14:12]);
            chk("n", exp_n[i], chan_n_state[14:12]);
            chk("m4", 32'h1, chan_muted[4]);
        end
        rd_chk("p word", 8'h60, 32'h00004000);
        rd_chk("n word", 8'h64, 32'h00001000);
        bus_wr(8'h68, 8'hFF, 4'h1);
        rd_chk("history", 8'h68, 32'h00000010);
        bus_wr(8'h58, 8'hEF, 4'h1);
        pulse(8'h10);
        chk("off4", 32'h0, chan_muted[4]);
        chk("p4", nr, chan_p_state[14:12]);
        bus_wr(8'h54, 8'h57, 4'h1);
        rd_chk("level3", 8'h54, 32'h00000057);
        test_done();
    end
endmodule

bind ocmc_top ocmc_top_checker i_ocmc_top_checker (
    .core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .src_valid_in, .chan_diff_mode, .chan_div_edge, .chan_muted,
    .chan_p_state, .chan_n_state
);
